// File: core/bgmc_defines.vh
`ifndef BGMC_DEFINES_VH
`define BGMC_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BGMC_ADDR_GEN_CFG 8'h03
`define BGMC_ADDR_MODE_SEL 8'h04
`define BGMC_GEN_CFG_RST 8'hD2
`define BGMC_MODE_SEL_RST 8'h80
// Writable bit masks; other bits keep reset value
`define BGMC_GEN_CFG_WMASK 8'hBA
`define BGMC_MODE_SEL_WMASK 8'hA0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BGMC_CRC_EN_BIT 7
`define BGMC_AUTO_ACK_BIT 5
`define BGMC_FILT_EN_BIT 4
`define BGMC_PASS_BIT 3
`define BGMC_OSC_AUTO_BIT 1
`define BGMC_FAILSAFE_BIT 7
`define BGMC_CRC_CLR_BIT 5
`define BGMC_DEV_ID_SEL_BIT 0
`define BGMC_DEV_ADDR_MSB 7
`define BGMC_DEV_ADDR_LSB 1
// ----------------------------------------
// Misc
// ----------------------------------------
`define BGMC_FILT_LEN 2
`define BGMC_CNT_W 8
`endif

// File: core/bgmc_glitch_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "bgmc_defines.vh"
module bgmc_glitch_filter #(
  parameter MIN_LEN = `BGMC_FILT_LEN
) (
  input wire clk,
  input wire rst_b,
  input wire enable,
  input wire din,
  output reg dout
);
  reg cand_r;
  reg [1:0] run_r;
  // ----------------------------------------
  // Accept a level only after MIN_LEN stable clocks
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      cand_r <= 1'b0;
      run_r <= 2'h0;
      dout <= 1'b0;
    end else begin
      cand_r <= din;
      if (din != cand_r) begin
        run_r <= 2'h1;
      end else if (run_r != 2'h3) begin
        run_r <= run_r + 2'h1;
      end
      if (!enable) begin
        dout <= din; // RULE4
      end else if (din == cand_r && run_r >= MIN_LEN - 1) begin
        dout <= din; // RULE4
      end
    end
  end
endmodule
`default_nettype wire

// File: core/bgmc_config.v
// Behaviour
// RULE1 - Config bit 7 enables CRC checker, reset D2
// RULE2 - Bit 5 acks remote writes immediately
// RULE3 - Auto-ack covers pass-all; applies per port
// RULE4 - Bit 4 rejects sync/enable pulses under two clocks
// RULE5 - Bit 3 forwards alias-matched transactions remotely
// RULE6 - Bit 1 switches to oscillator without clock
// RULE7 - Mode bit 7 picks failsafe level, reset 80
// RULE8 - Mode bit 5 holds CRC counters cleared
// RULE9 - Respond at strap or programmed address
// RULE10 - Reserved bits read reset values, ignore writes
// RULE11 - Disabled checker never increments error counters
`timescale 1ns/1ps
`default_nettype none
`include "bgmc_defines.vh"
module bgmc_config #(
  parameter CNT_W = `BGMC_CNT_W
) (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] dev_id_reg,
  input wire [6:0] strap_addr,
  input wire [6:0] i2c_target_addr,
  output reg addr_match,
  input wire second_port_select,
  input wire pass_all,
  input wire remote_write,
  input wire remote_ack,
  input wire alias_hit,
  output reg local_ack,
  output reg forward_req,
  input wire horizontal_sync_input,
  input wire vertical_sync_input,
  input wire display_enable_input,
  output reg hsync_out,
  output reg vsync_out,
  output reg display_enable_out,
  input wire tmds_clk_present,
  output reg use_int_osc,
  input wire inputs_valid,
  output reg failsafe_level,
  output reg crc_checker_en,
  input wire crc_err_evt,
  output reg [CNT_W-1:0] crc_err_cnt0,
  output reg [CNT_W-1:0] crc_err_cnt1
);
  reg [7:0] gen_cfg_r;
  reg [7:0] mode_sel_r;
  reg [7:0] gen_cfg_p1_r;
  reg [1:0] hsync_s_r;
  reg [1:0] vsync_s_r;
  reg [1:0] den_s_r;
  reg clk_pres_s1_r;
  reg clk_pres_s2_r;
  wire hsync_f;
  wire vsync_f;
  wire den_f;
  wire fs_drive;
  wire [7:0] port_cfg;
  wire [6:0] own_addr;

  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] val;
    begin
      if (&val) begin
        sat_inc = val;
      end else begin
        sat_inc = val + 1'b1;
      end
    end
  endfunction

  assign port_cfg = second_port_select ? gen_cfg_p1_r : gen_cfg_r; // RULE3
  assign own_addr = dev_id_reg[`BGMC_DEV_ID_SEL_BIT] ?
    dev_id_reg[`BGMC_DEV_ADDR_MSB:`BGMC_DEV_ADDR_LSB] : strap_addr; // RULE9
  assign fs_drive = ~mode_sel_r[`BGMC_FAILSAFE_BIT]; // RULE7

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      gen_cfg_r <= `BGMC_GEN_CFG_RST; // RULE1
      gen_cfg_p1_r <= `BGMC_GEN_CFG_RST;
      mode_sel_r <= `BGMC_MODE_SEL_RST; // RULE7
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `BGMC_ADDR_GEN_CFG) begin
        if (second_port_select) begin
          gen_cfg_p1_r <= merge(gen_cfg_p1_r, reg_wdata, `BGMC_GEN_CFG_WMASK); // RULE10
        end else begin
          gen_cfg_r <= merge(gen_cfg_r, reg_wdata, `BGMC_GEN_CFG_WMASK); // RULE10
        end
      end
      if (reg_wr && reg_addr == `BGMC_ADDR_MODE_SEL) begin
        mode_sel_r <= merge(mode_sel_r, reg_wdata, `BGMC_MODE_SEL_WMASK); // RULE10 RULE8
      end
      if (reg_rd) begin
        case (reg_addr)
          `BGMC_ADDR_GEN_CFG: begin
            reg_rdata <= port_cfg;
          end
          `BGMC_ADDR_MODE_SEL: begin
            reg_rdata <= mode_sel_r;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // I2C acknowledge and forwarding
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      addr_match <= 1'b0;
      local_ack <= 1'b0;
      forward_req <= 1'b0;
    end else begin
      addr_match <= (i2c_target_addr == own_addr); // RULE9
      if (remote_write && port_cfg[`BGMC_AUTO_ACK_BIT]) begin
        local_ack <= 1'b1; // RULE2 RULE3
      end else begin
        local_ack <= remote_write & remote_ack;
      end
      forward_req <= port_cfg[`BGMC_PASS_BIT] & (alias_hit | pass_all); // RULE5
    end
  end

  // ----------------------------------------
  // Input synchronisers and filters
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      hsync_s_r <= 2'h0;
      vsync_s_r <= 2'h0;
      den_s_r <= 2'h0;
      clk_pres_s1_r <= 1'b0;
      clk_pres_s2_r <= 1'b0;
    end else begin
      hsync_s_r <= {hsync_s_r[0], horizontal_sync_input};
      vsync_s_r <= {vsync_s_r[0], vertical_sync_input};
      den_s_r <= {den_s_r[0], display_enable_input};
      clk_pres_s1_r <= tmds_clk_present;
      clk_pres_s2_r <= clk_pres_s1_r;
    end
  end

  bgmc_glitch_filter u_hsync_filt (
    .clk(clk),
    .rst_b(rst_b),
    .enable(gen_cfg_r[`BGMC_FILT_EN_BIT]), // RULE4
    .din(hsync_s_r[1]),
    .dout(hsync_f)
  );

  bgmc_glitch_filter u_vsync_filt (
    .clk(clk),
    .rst_b(rst_b),
    .enable(gen_cfg_r[`BGMC_FILT_EN_BIT]), // RULE4
    .din(vsync_s_r[1]),
    .dout(vsync_f)
  );

  bgmc_glitch_filter u_den_filt (
    .clk(clk),
    .rst_b(rst_b),
    .enable(gen_cfg_r[`BGMC_FILT_EN_BIT]), // RULE4
    .din(den_s_r[1]),
    .dout(den_f)
  );

  // ----------------------------------------
  // Failsafe, clock source and CRC counters
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      display_enable_out <= 1'b0;
      failsafe_level <= 1'b0;
      use_int_osc <= 1'b0;
      crc_checker_en <= 1'b1;
      crc_err_cnt0 <= {CNT_W{1'b0}};
      crc_err_cnt1 <= {CNT_W{1'b0}};
    end else begin
      failsafe_level <= fs_drive; // RULE7
      hsync_out <= inputs_valid ? hsync_f : fs_drive; // RULE7
      vsync_out <= inputs_valid ? vsync_f : fs_drive; // RULE7
      display_enable_out <= inputs_valid ? den_f : fs_drive; // RULE7
      use_int_osc <= gen_cfg_r[`BGMC_OSC_AUTO_BIT] & ~clk_pres_s2_r; // RULE6
      crc_checker_en <= port_cfg[`BGMC_CRC_EN_BIT]; // RULE1
      if (mode_sel_r[`BGMC_CRC_CLR_BIT]) begin
        crc_err_cnt0 <= {CNT_W{1'b0}}; // RULE8
        crc_err_cnt1 <= {CNT_W{1'b0}};
      end else if (crc_err_evt && port_cfg[`BGMC_CRC_EN_BIT]) begin // RULE11
        if (second_port_select) begin
          crc_err_cnt1 <= sat_inc(crc_err_cnt1);
        end else begin
          crc_err_cnt0 <= sat_inc(crc_err_cnt0);
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test/bgmc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bgmc_asserts #(
  parameter CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic addr_match,
  input wire logic pass_all,
  input wire logic alias_hit,
  input wire logic forward_req,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] dev_id_reg,
  input wire logic [6:0] strap_addr,
  input wire logic [6:0] i2c_target_addr,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic display_enable_out,
  input wire logic tmds_clk_present,
  input wire logic use_int_osc,
  input wire logic inputs_valid,
  input wire logic failsafe_level,
  input wire logic crc_checker_en,
  input wire logic [CNT_W-1:0] crc_err_cnt0,
  input wire logic [CNT_W-1:0] crc_err_cnt1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd_mode;
    reg_rd && reg_addr == 8'h04;
  endsequence
  sequence s_addr_steady;
    ($stable(i2c_target_addr) && $stable(dev_id_reg)) [*2];
  endsequence
  AST_RSV_CFG: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rdata[6] && !reg_rdata[2] && !reg_rdata[0])
    else $error("config reserved bits wrong");
  AST_RSV_MODE: assert property (s_rd_mode |=> (reg_rdata & 8'h5F) == 8'h00)
    else $error("mode reserved bits wrong");
  AST_CLR_HELD: assert property (
    s_rd_mode ##1 reg_rdata[5] |-> crc_err_cnt0 == 0 && crc_err_cnt1 == 0)
    else $error("counters not held cleared");
  AST_CNT_OFF: assert property (
    !crc_checker_en |-> crc_err_cnt0 <= $past(crc_err_cnt0) &&
    crc_err_cnt1 <= $past(crc_err_cnt1))
    else $error("counter moved while checker off");
  AST_FAILSAFE: assert property (!inputs_valid [*3] |-> hsync_out == failsafe_level &&
    vsync_out == failsafe_level && display_enable_out == failsafe_level)
    else $error("outputs not at failsafe level");
  AST_OSC: assert property (tmds_clk_present [*5] |-> !use_int_osc)
    else $error("oscillator used with clock present");
  AST_FWD: assert property ((!alias_hit && !pass_all) [*2] |-> !forward_req)
    else $error("forward without match");
  AST_ADDR: assert property (s_addr_steady |-> addr_match ==
    (i2c_target_addr == (dev_id_reg[0] ? dev_id_reg[7:1] : strap_addr)))
    else $error("address match wrong");
  AST_CRC_RST: assert property ($rose(rst_b) |-> crc_checker_en)
    else $error("checker off after reset");
endmodule
bind bgmc_config bgmc_asserts #(.CNT_W(CNT_W)) i_bgmc_asserts (.clk, .rst_b, .reg_rd,
  .addr_match, .pass_all, .alias_hit, .forward_req, .reg_addr, .reg_rdata, .dev_id_reg,
  .strap_addr, .i2c_target_addr, .hsync_out, .vsync_out, .display_enable_out, .tmds_clk_present,
  .use_int_osc, .inputs_valid, .failsafe_level, .crc_checker_en, .crc_err_cnt0, .crc_err_cnt1);
`default_nettype wire

// File: test/bgmc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bgmc_partner (
  input wire logic clk,
  input wire logic remote_write,
  input wire logic nak,
  input wire logic err_on,
  output logic remote_ack,
  output logic crc_err_evt
);
  // Remote end: acks a write next cycle unless told to refuse; error pulses on request
  always @(posedge clk) begin
    remote_ack <= remote_write && !nak;
    crc_err_evt <= err_on && !crc_err_evt;
  end
endmodule
`default_nettype wire

// File: test/bridge_general_mode_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_general_mode_config_tb;
  logic clk, rst_b, reg_wr, reg_rd, second_port_select, pass_all, remote_write, alias_hit;
  logic err_on, nak, horizontal_sync_input, vertical_sync_input, display_enable_input, seen;
  logic tmds_clk_present, inputs_valid, remote_ack, crc_err_evt, addr_match, local_ack;
  logic forward_req, hsync_out, vsync_out, display_enable_out, use_int_osc, failsafe_level;
  logic crc_checker_en;
  logic [7:0] reg_addr, reg_wdata, dev_id_reg, reg_rdata, crc_err_cnt0, crc_err_cnt1, c;
  logic [6:0] strap_addr, i2c_target_addr;
  int miscompares = 0, check_count = 0;
  bgmc_config i_bgmc_config (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .dev_id_reg, .strap_addr, .i2c_target_addr, .addr_match, .second_port_select, .pass_all,
    .remote_write, .remote_ack, .alias_hit, .local_ack, .forward_req, .horizontal_sync_input,
    .vertical_sync_input, .display_enable_input, .hsync_out, .vsync_out, .display_enable_out,
    .tmds_clk_present, .use_int_osc, .inputs_valid, .failsafe_level, .crc_checker_en,
    .crc_err_evt, .crc_err_cnt0, .crc_err_cnt1);
  bgmc_partner i_bgmc_partner (.clk, .remote_write, .nak, .err_on, .remote_ack, .crc_err_evt);
  task automatic give_verdict;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
    cy(1);
    reg_wr = 1'h0;
    cy(3);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {reg_rd, reg_addr} = {1'h1, a};
    cy(1);
    reg_rd = 1'h0;
    chk(reg_rdata, e);
    cy(1);
  endtask
  // Sync pulse of n clocks; e says whether it must get through
  task automatic pulse(input int n, input logic e);
    seen = 1'h0;
    horizontal_sync_input = 1'h1;
    cy(n);
    horizontal_sync_input = 1'h0;
    repeat (8) begin
      cy(1);
      seen = seen | hsync_out;
    end
    chk(seen, e);
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    miscompares++;
    give_verdict;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, second_port_select, pass_all, remote_write, alias_hit} = 7'h00;
    {err_on, horizontal_sync_input, vertical_sync_input, display_enable_input, nak} = 5'h01;
    {tmds_clk_present, inputs_valid, reg_addr, reg_wdata, dev_id_reg} = 26'h3000000;
    {strap_addr, i2c_target_addr} = 14'h1500;
    cy(2);
    rst_b = 1'h1;
    cy(1);
    chk(crc_checker_en, 1'h1);
    chk(failsafe_level, 1'h0);
    rd(8'h03, 8'hD2);
    rd(8'h04, 8'h80);
    rd(8'h05, 8'h00);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'hFA);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'hA0);
    wr(8'h04, 8'h00);
    chk(failsafe_level, 1'h1);
    inputs_valid = 1'h0;
    cy(4);
    chk({hsync_out, vsync_out, display_enable_out}, 3'h7);
    inputs_valid = 1'h1;
    err_on = 1'h1;
    cy(10);
    second_port_select = 1'h1;
    cy(10);
    second_port_select = 1'h0;
    chk(|crc_err_cnt0, 1'h1);
    chk(|crc_err_cnt1, 1'h1);
    wr(8'h04, 8'h20);
    cy(10);
    rd(8'h04, 8'h20);
    chk(crc_err_cnt0, 8'h00);
    chk(crc_err_cnt1, 8'h00);
    wr(8'h04, 8'h80);
    wr(8'h03, 8'h00);
    chk(crc_checker_en, 1'h0);
    c = crc_err_cnt0;
    chk(c != 8'h00, 1'h1);
    cy(10);
    chk(crc_err_cnt0, c);
    err_on = 1'h0;
    pulse(1, 1'h1);
    tmds_clk_present = 1'h0;
    cy(6);
    chk(use_int_osc, 1'h0);
    wr(8'h03, 8'hD2);
    chk(use_int_osc, 1'h1);
    tmds_clk_present = 1'h1;
    pulse(1, 1'h0);
    pulse(2, 1'h1);
    remote_write = 1'h1;
    cy(4);
    chk(local_ack, 1'h0);
    nak = 1'h0;
    cy(3);
    chk(local_ack, 1'h1);
    nak = 1'h1;
    wr(8'h03, 8'hF2);
    chk(local_ack, 1'h1);
    second_port_select = 1'h1;
    cy(3);
    chk(local_ack, 1'h0);
    pass_all = 1'h1;
    wr(8'h03, 8'hF2);
    chk(local_ack, 1'h1);
    {remote_write, second_port_select, pass_all} = 3'h0;
    wr(8'h03, 8'hDA);
    alias_hit = 1'h1;
    cy(3);
    chk(forward_req, 1'h1);
    alias_hit = 1'h0;
    cy(3);
    chk(forward_req, 1'h0);
    i2c_target_addr = 7'h2A;
    cy(3);
    chk(addr_match, 1'h1);
    dev_id_reg = 8'h99;
    cy(3);
    chk(addr_match, 1'h0);
    i2c_target_addr = 7'h4C;
    cy(3);
    chk(addr_match, 1'h1);
    rst_b = 1'h0;
    cy(2);
    rst_b = 1'h1;
    cy(1);
    rd(8'h03, 8'hD2);
    second_port_select = 1'h1;
    rd(8'h03, 8'hD2);
    give_verdict;
  end
endmodule
`default_nettype wire
